//--- logic/redriver_cfg_pkg.sv
/*
 * Shared constants and carrier types for the redriver configuration select logic.
 * Assumes four-level pins and the mode strap arrive already resolved to two-bit codes.
 */
package redriver_cfg_pkg;

    // Four-level pin states
    localparam logic [1:0] LVL_LOW   = 2'h0;
    localparam logic [1:0] LVL_RES   = 2'h1;
    localparam logic [1:0] LVL_OPEN  = 2'h2;
    localparam logic [1:0] LVL_HIGH  = 2'h3;

    // Mode strap codes
    localparam logic [1:0] STRAP_LOW   = 2'h0;
    localparam logic [1:0] STRAP_HIGH  = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;

    // Applied configuration source
    localparam logic [1:0] MODE_PIN    = 2'h0;
    localparam logic [1:0] MODE_SLAVE  = 2'h1;
    localparam logic [1:0] MODE_MASTER = 2'h2;

    localparam int NUM_LANES = 4;

    // Register map: lane n at LANE_BASE + n * LANE_STRIDE
    localparam logic [7:0] LANE_BASE   = 8'h00;
    localparam logic [7:0] LANE_STRIDE = 8'h04;
    localparam logic [1:0] OFS_EQ      = 2'h0;
    localparam logic [1:0] OFS_SWING   = 2'h1;
    localparam logic [1:0] OFS_DEEMPH  = 2'h2;
    localparam logic [1:0] OFS_TERM    = 2'h3;
    localparam logic [7:0] ADDR_OVR    = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h11;

    // Override register fields
    localparam int OVR_IDLE_EN  = 0;
    localparam int OVR_IDLE_LSB = 1;

    // Reset values
    localparam logic [7:0] RST_EQ     = 8'h00;
    localparam logic [2:0] RST_SWING  = 3'h3;
    localparam logic [1:0] RST_DEEMPH = 2'h0;
    localparam logic       RST_TERM   = 1'b0;
    localparam logic [1:0] RST_IDLE   = 2'h0;

    // Swing codes: 0.6, 0.8, 0.9, 1.0, 1.1, 1.2 Vpp
    localparam logic [2:0] SW_0P6 = 3'h0;
    localparam logic [2:0] SW_0P8 = 3'h1;
    localparam logic [2:0] SW_0P9 = 3'h2;
    localparam logic [2:0] SW_1P0 = 3'h3;
    localparam logic [2:0] SW_1P1 = 3'h4;
    localparam logic [2:0] SW_1P2 = 3'h5;

    // De-emphasis codes: 0, -3.5, -6, -9 dB
    localparam logic [1:0] DM_0    = 2'h0;
    localparam logic [1:0] DM_3P5  = 2'h1;
    localparam logic [1:0] DM_6    = 2'h2;
    localparam logic [1:0] DM_9    = 2'h3;

    typedef struct packed {
        logic [1:0] eq_hi;
        logic [1:0] eq_lo;
        logic [1:0] dm_hi;
        logic [1:0] dm_lo;
    } side_pins_t;

    typedef struct packed {
        logic [7:0] equalizer_code;
        logic [2:0] output_swing;
        logic [1:0] deemph_level;
        logic       term_dis;
    } lane_cfg_t;

    typedef struct packed {
        logic [7:0] equalizer_code;
        logic [2:0] output_swing;
        logic [1:0] deemph_level;
    } side_setting_t;

endpackage : redriver_cfg_pkg

//--- logic/pin_setting_decode.sv
/*
 * Turns one side's four-level equalizer and de-emphasis pins into settings.
 * Assumes the pin states are already resolved two-bit levels; purely combinational.
 */
`timescale 1ns/1ps
module pin_setting_decode (
    input  wire redriver_cfg_pkg::side_pins_t    pins,
    output redriver_cfg_pkg::side_setting_t      setting
);
    logic [3:0] eq_idx;
    logic [3:0] dm_idx;
    logic [4:0] sw_dm;

    assign eq_idx = {pins.eq_hi, pins.eq_lo};
    assign dm_idx = {pins.dm_hi, pins.dm_lo};

    always_comb
    begin
        case (eq_idx)
            4'h0:    setting.equalizer_code = 8'h00;
            4'h1:    setting.equalizer_code = 8'h01;
            4'h2:    setting.equalizer_code = 8'h02;
            4'h3:    setting.equalizer_code = 8'h03;
            4'h4:    setting.equalizer_code = 8'h07;
            4'h5:    setting.equalizer_code = 8'h15;
            4'h6:    setting.equalizer_code = 8'h0B;
            4'h7:    setting.equalizer_code = 8'h0F;
            4'h8:    setting.equalizer_code = 8'h55;
            4'h9:    setting.equalizer_code = 8'h1F;
            4'hA:    setting.equalizer_code = 8'h2F;
            4'hB:    setting.equalizer_code = 8'h3F;
            4'hC:    setting.equalizer_code = 8'hAA;
            4'hD:    setting.equalizer_code = 8'h7F;
            4'hE:    setting.equalizer_code = 8'hBF;
            default: setting.equalizer_code = 8'hFF;
        endcase
        // Swing follows the de-emphasis step so the inner eye stays usable
        case (dm_idx)
            4'h0:    sw_dm = {redriver_cfg_pkg::SW_0P6, redriver_cfg_pkg::DM_0};
            4'h1:    sw_dm = {redriver_cfg_pkg::SW_0P8, redriver_cfg_pkg::DM_0};
            4'h2:    sw_dm = {redriver_cfg_pkg::SW_0P8, redriver_cfg_pkg::DM_3P5};
            4'h3:    sw_dm = {redriver_cfg_pkg::SW_0P9, redriver_cfg_pkg::DM_0};
            4'h4:    sw_dm = {redriver_cfg_pkg::SW_0P9, redriver_cfg_pkg::DM_3P5};
            4'h5:    sw_dm = {redriver_cfg_pkg::SW_0P9, redriver_cfg_pkg::DM_6};
            4'h6:    sw_dm = {redriver_cfg_pkg::SW_1P0, redriver_cfg_pkg::DM_0};
            4'h7:    sw_dm = {redriver_cfg_pkg::SW_1P0, redriver_cfg_pkg::DM_3P5};
            4'h8:    sw_dm = {redriver_cfg_pkg::SW_1P0, redriver_cfg_pkg::DM_6};
            4'h9:    sw_dm = {redriver_cfg_pkg::SW_1P1, redriver_cfg_pkg::DM_0};
            4'hA:    sw_dm = {redriver_cfg_pkg::SW_1P1, redriver_cfg_pkg::DM_3P5};
            4'hB:    sw_dm = {redriver_cfg_pkg::SW_1P1, redriver_cfg_pkg::DM_6};
            4'hC:    sw_dm = {redriver_cfg_pkg::SW_1P2, redriver_cfg_pkg::DM_0};
            4'hD:    sw_dm = {redriver_cfg_pkg::SW_1P2, redriver_cfg_pkg::DM_3P5};
            4'hE:    sw_dm = {redriver_cfg_pkg::SW_1P2, redriver_cfg_pkg::DM_6};
            default: sw_dm = {redriver_cfg_pkg::SW_1P2, redriver_cfg_pkg::DM_9};
        endcase
        {setting.output_swing, setting.deemph_level} = sw_dm;
    end

endmodule : pin_setting_decode

//--- logic/redriver_config_select.sv
/*
 * Configuration source select for a dual-side redriver: pins, slave registers or
 * EEPROM-loaded registers, chosen by the mode strap.
 * Assumes all inputs are synchronous to clk and four-level pins arrive as two-bit levels.
 * The EEPROM loader writes through the same register port as the slave interface.
 */
`timescale 1ns/1ps
module redriver_config_select #(
    parameter int LANES = redriver_cfg_pkg::NUM_LANES
) (
    input  wire logic                                   clk,
    input  wire logic                                   reset,
    input  wire logic                                   reset_pin,
    input  wire logic [1:0]                             mgmt_mode_strap,
    input  wire logic [1:0]                             idle_threshold_pin,
    input  wire redriver_cfg_pkg::side_pins_t           dside_pins,
    input  wire redriver_cfg_pkg::side_pins_t           sside_pins,
    input  wire logic [7:0]                             reg_addr,
    input  wire logic [7:0]                             reg_wdata,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    output redriver_cfg_pkg::lane_cfg_t [LANES-1:0]     lane_cfg,
    output logic [1:0]                                  idle_threshold,
    output logic [3:0]                                  slave_addr_inputs,
    output logic [1:0]                                  cfg_mode,
    output logic [7:0]                                  reg_rdata
);
    typedef struct packed {
        redriver_cfg_pkg::lane_cfg_t [LANES-1:0] regs;
        logic                                    ovr_idle;
        logic [1:0]                              idle_val;
        redriver_cfg_pkg::lane_cfg_t [LANES-1:0] out;
        logic [1:0]                              idle_out;
        logic [3:0]                              addr_out;
        logic [1:0]                              mode;
        logic [7:0]                              rdata;
    } state_t;

    state_t                          s_q;
    state_t                          s_d;
    redriver_cfg_pkg::side_setting_t side_set [2];

    function automatic logic lane_hit(input logic [7:0] addr, input int lane);
        logic [7:0] base;
        base = 8'(redriver_cfg_pkg::LANE_BASE + 8'(lane) * redriver_cfg_pkg::LANE_STRIDE);
        return addr[7:2] == base[7:2];
    endfunction : lane_hit

    function automatic redriver_cfg_pkg::lane_cfg_t lane_default();
        redriver_cfg_pkg::lane_cfg_t c;
        c.equalizer_code = redriver_cfg_pkg::RST_EQ;
        c.output_swing   = redriver_cfg_pkg::RST_SWING;
        c.deemph_level   = redriver_cfg_pkg::RST_DEEMPH;
        c.term_dis       = redriver_cfg_pkg::RST_TERM;
        return c;
    endfunction : lane_default

    // High half of a four-level pin reads as address one
    function automatic logic level_bit(input logic [1:0] lvl);
        return lvl[1];
    endfunction : level_bit

    pin_setting_decode u_dside (
        .pins    (dside_pins),
        .setting (side_set[0])
    );

    pin_setting_decode u_sside (
        .pins    (sside_pins),
        .setting (side_set[1])
    );

    always_comb
    begin
        logic pin_mode;
        logic slave_mode;
        logic clear_regs;
        int   side;
        pin_mode   = 1'b0;
        slave_mode = 1'b0;
        clear_regs = 1'b0;
        side       = 0;
        s_d        = s_q;

        pin_mode   = (mgmt_mode_strap == redriver_cfg_pkg::STRAP_LOW);
        slave_mode = (mgmt_mode_strap == redriver_cfg_pkg::STRAP_HIGH);
        case (mgmt_mode_strap)
            redriver_cfg_pkg::STRAP_LOW:   s_d.mode = redriver_cfg_pkg::MODE_PIN;
            redriver_cfg_pkg::STRAP_HIGH:  s_d.mode = redriver_cfg_pkg::MODE_SLAVE;
            default:                       s_d.mode = redriver_cfg_pkg::MODE_MASTER;
        endcase

        // Strap low holds the bank at defaults; the reset pin is ignored while high
        clear_regs = pin_mode || (reset_pin && !slave_mode);

        if (clear_regs)
        begin
            for (int n = 0; n < LANES; n++)
            begin
                s_d.regs[n] = lane_default();
            end
            s_d.ovr_idle = 1'b0;
            s_d.idle_val = redriver_cfg_pkg::RST_IDLE;
        end
        else if (reg_wr)
        begin
            for (int n = 0; n < LANES; n++)
            begin
                if (lane_hit(reg_addr, n))
                begin
                    case (reg_addr[1:0])
                        redriver_cfg_pkg::OFS_EQ:
                            s_d.regs[n].equalizer_code = reg_wdata;
                        redriver_cfg_pkg::OFS_SWING:
                            s_d.regs[n].output_swing = reg_wdata[2:0];
                        redriver_cfg_pkg::OFS_DEEMPH:
                            s_d.regs[n].deemph_level = reg_wdata[1:0];
                        default:
                            s_d.regs[n].term_dis = reg_wdata[0];
                    endcase
                end
            end
            if (reg_addr == redriver_cfg_pkg::ADDR_OVR)
            begin
                s_d.ovr_idle = reg_wdata[redriver_cfg_pkg::OVR_IDLE_EN];
                s_d.idle_val = reg_wdata[redriver_cfg_pkg::OVR_IDLE_LSB +: 2];
            end
        end

        // Applied settings: pins only in pin mode, registers otherwise
        for (int n = 0; n < LANES; n++)
        begin
            side = (n < LANES / 2) ? 0 : 1;
            if (pin_mode)
            begin
                s_d.out[n].equalizer_code = side_set[side].equalizer_code;
                s_d.out[n].output_swing   = side_set[side].output_swing;
                s_d.out[n].deemph_level   = side_set[side].deemph_level;
                s_d.out[n].term_dis       = redriver_cfg_pkg::RST_TERM;
            end
            else
            begin
                s_d.out[n] = s_q.regs[n];
            end
        end

        // Idle threshold pin stays live until overridden
        if (!pin_mode && s_q.ovr_idle)
        begin
            s_d.idle_out = s_q.idle_val;
        end
        else
        begin
            s_d.idle_out = idle_threshold_pin;
        end

        // Pins double as address straps only in slave mode
        if (slave_mode)
        begin
            s_d.addr_out = {level_bit(sside_pins.eq_hi), level_bit(sside_pins.eq_lo),
                            level_bit(dside_pins.eq_hi), level_bit(dside_pins.eq_lo)};
        end
        else
        begin
            s_d.addr_out = 4'h0;
        end

        s_d.rdata = 8'h00;
        if (reg_rd)
        begin
            for (int n = 0; n < LANES; n++)
            begin
                if (lane_hit(reg_addr, n))
                begin
                    case (reg_addr[1:0])
                        redriver_cfg_pkg::OFS_EQ:
                            s_d.rdata = s_q.regs[n].equalizer_code;
                        redriver_cfg_pkg::OFS_SWING:
                            s_d.rdata = {5'h00, s_q.regs[n].output_swing};
                        redriver_cfg_pkg::OFS_DEEMPH:
                            s_d.rdata = {6'h00, s_q.regs[n].deemph_level};
                        default:
                            s_d.rdata = {7'h00, s_q.regs[n].term_dis};
                    endcase
                end
            end
            if (reg_addr == redriver_cfg_pkg::ADDR_OVR)
            begin
                s_d.rdata = {5'h00, s_q.idle_val, s_q.ovr_idle};
            end
            if (reg_addr == redriver_cfg_pkg::ADDR_STATUS)
            begin
                s_d.rdata = {2'h0, s_q.idle_out, s_q.mode, mgmt_mode_strap};
            end
        end
    end

    // Power-up reset always restores defaults, whatever the strap
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int n = 0; n < LANES; n++)
            begin
                s_q.regs[n] <= lane_default();
                s_q.out[n]  <= lane_default();
            end
            s_q.ovr_idle <= 1'b0;
            s_q.idle_val <= redriver_cfg_pkg::RST_IDLE;
            s_q.idle_out <= redriver_cfg_pkg::RST_IDLE;
            s_q.addr_out <= 4'h0;
            s_q.mode     <= redriver_cfg_pkg::MODE_PIN;
            s_q.rdata    <= 8'h00;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign lane_cfg          = s_q.out;
    assign idle_threshold    = s_q.idle_out;
    assign slave_addr_inputs = s_q.addr_out;
    assign cfg_mode          = s_q.mode;
    assign reg_rdata         = s_q.rdata;

endmodule : redriver_config_select

//--- tb/redriver_config_select_monitor.sv
/*
 * Port-level assertions for the redriver configuration select block.
 * Assumes it is bound to the block and sees only the block's ports.
 */
`timescale 1ns/1ps
module redriver_cfg_checker #(
    parameter int LANES = 4
) (
    input wire logic                                    clk,
    input wire logic                                    reset,
    input wire logic [1:0]                              mgmt_mode_strap,
    input wire logic [1:0]                              idle_threshold_pin,
    input wire redriver_cfg_pkg::side_pins_t            dside_pins,
    input wire redriver_cfg_pkg::side_pins_t            sside_pins,
    input wire logic [7:0]                              reg_addr,
    input wire logic                                    reg_rd,
    input wire redriver_cfg_pkg::lane_cfg_t [LANES-1:0] lane_cfg,
    input wire logic [1:0]                              idle_threshold,
    input wire logic [3:0]                              slave_addr_inputs,
    input wire logic [1:0]                              cfg_mode,
    input wire logic [7:0]                              reg_rdata
);
    // Pin-mode equalizer codes, indexed by {upper level, lower level}
    localparam logic [7:0] EQT [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0B, 8'h0F,
                                        8'h55, 8'h1F, 8'h2F, 8'h3F, 8'hAA, 8'h7F, 8'hBF, 8'hFF};
    logic pin_m;
    logic slv_m;
    assign pin_m = mgmt_mode_strap == redriver_cfg_pkg::STRAP_LOW;
    assign slv_m = mgmt_mode_strap == redriver_cfg_pkg::STRAP_HIGH;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_mode_pin;
        pin_m |=> cfg_mode == redriver_cfg_pkg::MODE_PIN;
    endproperty
    a_mode_pin: assert property (p_mode_pin) else $error("mode not pin");
    property p_mode_slave;
        slv_m |=> cfg_mode == redriver_cfg_pkg::MODE_SLAVE;
    endproperty
    a_mode_slave: assert property (p_mode_slave) else $error("mode not slave");
    property p_addr;
        slv_m |=> slave_addr_inputs == {$past(sside_pins.eq_hi[1]), $past(sside_pins.eq_lo[1]),
                                        $past(dside_pins.eq_hi[1]), $past(dside_pins.eq_lo[1])};
    endproperty
    a_addr: assert property (p_addr) else $error("address inputs wrong");
    property p_eq_d;
        pin_m |=> lane_cfg[0].equalizer_code == EQT[{$past(dside_pins.eq_hi),
                                                      $past(dside_pins.eq_lo)}];
    endproperty
    a_eq_d: assert property (p_eq_d) else $error("dside equalizer wrong");
    property p_eq_s;
        pin_m |=> lane_cfg[3].equalizer_code == EQT[{$past(sside_pins.eq_hi),
                                                      $past(sside_pins.eq_lo)}];
    endproperty
    a_eq_s: assert property (p_eq_s) else $error("sside equalizer wrong");
    property p_dm9;
        pin_m && dside_pins.dm_hi == redriver_cfg_pkg::LVL_HIGH
              && dside_pins.dm_lo == redriver_cfg_pkg::LVL_HIGH
        |=> lane_cfg[1].output_swing == redriver_cfg_pkg::SW_1P2
            && lane_cfg[1].deemph_level == redriver_cfg_pkg::DM_9;
    endproperty
    a_dm9: assert property (p_dm9) else $error("swing not paired");
    property p_idle;
        pin_m |=> idle_threshold == $past(idle_threshold_pin);
    endproperty
    a_idle: assert property (p_idle) else $error("idle threshold wrong");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_pin_regs;
        pin_m && reg_rd && reg_addr == redriver_cfg_pkg::LANE_BASE
        |=> reg_rdata == redriver_cfg_pkg::RST_EQ;
    endproperty
    a_pin_regs: assert property (p_pin_regs) else $error("register not default");

    c_to_slave: cover property (pin_m ##1 slv_m);
    c_rd_rd: cover property (reg_rd ##1 reg_rd);
    c_dm9: cover property (pin_m && dside_pins.dm_hi == redriver_cfg_pkg::LVL_HIGH);
endmodule : redriver_cfg_checker

//--- tb/cfg_host.sv
/*
 * Host model driving the register port of the redriver configuration block.
 * Assumes one strobe per cycle and that the block never stalls.
 */
`timescale 1ns/1ps
module cfg_host (
    input wire logic  clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic       reg_wr,
    output logic       reg_rd
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Each op owns one cycle, so back-to-back calls give gapless strobes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= ~reg_wdata;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
    endtask : rd
    task automatic idle;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask : idle
endmodule : cfg_host

//--- tb/tb_redriver_config_select.sv
/*
 * Self-checking bench for the redriver configuration select block.
 * Assumes the package and the host model are compiled first.
 */
`timescale 1ns/1ps
module tb_redriver_config_select;
    localparam logic [7:0] EQT [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h15, 8'h0B, 8'h0F,
                                        8'h55, 8'h1F, 8'h2F, 8'h3F, 8'hAA, 8'h7F, 8'hBF, 8'hFF};
    localparam logic [2:0] SWT [16] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3,
                                        3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5, 3'h5};
    localparam logic [1:0] DMT [16] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1,
                                        2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};
    localparam redriver_cfg_pkg::lane_cfg_t DEF_LANE = {redriver_cfg_pkg::RST_EQ,
        redriver_cfg_pkg::RST_SWING, redriver_cfg_pkg::RST_DEEMPH, redriver_cfg_pkg::RST_TERM};
    logic                                clk = 1'b0;
    logic                                reset, reset_pin, reg_wr, reg_rd, look, rd_d;
    logic [1:0]                          mgmt_mode_strap, idle_threshold_pin, idle_threshold;
    logic [1:0]                          cfg_mode, idle_e;
    redriver_cfg_pkg::side_pins_t        dside_pins, sside_pins, d, s;
    logic [7:0]                          reg_addr, reg_wdata, reg_rdata;
    logic [3:0]                          slave_addr_inputs, addr_e;
    redriver_cfg_pkg::lane_cfg_t [3:0]   lane_cfg, lanes_e;
    logic [31:0]                         seed;
    int                                  mismatches, tests_run;
    logic [7:0]                          rq[$];
    logic [63:0]                         sq[$];

    redriver_config_select #(.LANES(4)) dut (.clk, .reset, .reset_pin, .mgmt_mode_strap,
        .idle_threshold_pin, .dside_pins, .sside_pins, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .lane_cfg, .idle_threshold, .slave_addr_inputs, .cfg_mode, .reg_rdata);
    cfg_host host (.clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

    always #10 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs
    function automatic redriver_cfg_pkg::lane_cfg_t pin_lane(input logic [7:0] p);
        return {EQT[p[7:4]], SWT[p[3:0]], DMT[p[3:0]], 1'b0};
    endfunction : pin_lane
    task automatic chk8(input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk8
    task automatic chk64(input logic [63:0] e, input logic [63:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR %0t exp %h got %h", $time, e, g);
        end
    endtask : chk64
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rq.push_back(e);
        host.rd(a);
    endtask : rd
    // Note the expected outputs, then flag them for sampling one edge later
    task automatic expect_out(input logic [1:0] mode);
        @(posedge clk);
        sq.push_back({lanes_e, idle_e, addr_e, mode});
        look <= 1'b1;
        @(posedge clk);
        look <= 1'b0;
    endtask : expect_out
    task automatic results;
        if (mismatches == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    always @(posedge clk)
    begin
        if (rd_d)
            chk8(rq.pop_front(), reg_rdata);
        if (look)
            chk64(sq.pop_front(), {lane_cfg, idle_threshold, slave_addr_inputs, cfg_mode});
        rd_d <= reg_rd;
    end

    // Whole run is under a hundred cycles; this is ample headroom
    initial
    begin
        #200us;
        mismatches++;
        results();
    end

    initial
    begin
        reset = 1'b1;
        reset_pin = 1'b0;
        mgmt_mode_strap = redriver_cfg_pkg::STRAP_LOW;
        idle_threshold_pin = 2'h0;
        dside_pins = 8'h00;
        sside_pins = 8'h00;
        look = 1'b0;
        seed = 32'd62245;
        addr_e = 4'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            d = {i[3:0], i[3:0]};
            s = seed[7:0];
            dside_pins <= d;
            sside_pins <= s;
            idle_threshold_pin <= i[1:0];
            lanes_e = {pin_lane(s), pin_lane(s), pin_lane(d), pin_lane(d)};
            idle_e = i[1:0];
            expect_out(redriver_cfg_pkg::MODE_PIN);
        end
        host.wr(redriver_cfg_pkg::LANE_BASE, 8'h5A);
        rd(redriver_cfg_pkg::LANE_BASE, redriver_cfg_pkg::RST_EQ);
        rd(8'h01, {5'h00, redriver_cfg_pkg::RST_SWING});
        host.idle();
        mgmt_mode_strap <= redriver_cfg_pkg::STRAP_HIGH;
        lanes_e = {4{DEF_LANE}};
        addr_e = {s.eq_hi[1], s.eq_lo[1], d.eq_hi[1], d.eq_lo[1]};
        expect_out(redriver_cfg_pkg::MODE_SLAVE);
        for (int n = 0; n < 4; n++)
        begin
            seed = xs(seed);
            lanes_e[n] = {seed[7:0], n[2:0], n[1:0], n[0]};
            host.wr(8'(4 * n), seed[7:0]);
            host.wr(8'(4 * n + 1), {5'h00, n[2:0]});
            host.wr(8'(4 * n + 2), {6'h00, n[1:0]});
            host.wr(8'(4 * n + 3), {7'h00, n[0]});
        end
        for (int n = 0; n < 4; n++)
            rd(8'(4 * n), lanes_e[n].equalizer_code);
        host.wr(redriver_cfg_pkg::ADDR_OVR, 8'h05);
        host.idle();
        idle_threshold_pin <= 2'h1;
        idle_e = 2'h2;
        expect_out(redriver_cfg_pkg::MODE_SLAVE);
        rd(redriver_cfg_pkg::ADDR_OVR, 8'h05);
        rd(redriver_cfg_pkg::ADDR_STATUS, 8'h25);
        rd(8'h20, 8'h00);
        host.idle();
        reset_pin <= 1'b1;
        repeat (3) @(posedge clk);
        reset_pin <= 1'b0;
        expect_out(redriver_cfg_pkg::MODE_SLAVE);
        mgmt_mode_strap <= redriver_cfg_pkg::STRAP_FLOAT;
        addr_e = 4'h0;
        expect_out(redriver_cfg_pkg::MODE_MASTER);
        reset_pin <= 1'b1;
        repeat (2) @(posedge clk);
        reset_pin <= 1'b0;
        lanes_e = {4{DEF_LANE}};
        idle_e = 2'h1;
        expect_out(redriver_cfg_pkg::MODE_MASTER);
        host.wr(redriver_cfg_pkg::LANE_BASE, 8'h3C);
        rd(redriver_cfg_pkg::LANE_BASE, 8'h3C);
        host.idle();
        mgmt_mode_strap <= redriver_cfg_pkg::STRAP_LOW;
        @(posedge clk);
        mgmt_mode_strap <= redriver_cfg_pkg::STRAP_HIGH;
        rd(redriver_cfg_pkg::LANE_BASE, redriver_cfg_pkg::RST_EQ);
        host.idle();
        repeat (3) @(posedge clk);
        results();
    end
endmodule : tb_redriver_config_select

bind redriver_config_select redriver_cfg_checker #(.LANES(LANES)) mon (.clk, .reset,
    .mgmt_mode_strap, .idle_threshold_pin, .dside_pins, .sside_pins, .reg_addr, .reg_rd,
    .lane_cfg, .idle_threshold, .slave_addr_inputs, .cfg_mode, .reg_rdata);
